// >>> pcbm_params.svh
// What this block does
// (R1) Failure end: policy 01 turns supply on, 10 restores previous state.
// (R2) Policy calling for supply off leaves the button output untouched.
// (R3) Enabled front button held low holds button output low throughout.
// (R4) Recovery pulse on button output lasts at least 0.5 s, under 4 s.
// (R5) Supply enable output is always the inverse of sleep state input; the code inverts it one clock late and holds it high in reset.
// (R6) Hub interprets button output and drives sleep state, switching supply.
// (R7) Hub after-outage bit must be 1 when recovery is used.
// (R8) After standby rises above trip level, delay then release resume reset.
// (R9) Battery below 1.2 V on battery alone: battery reset at standby reset.
// (R10) Battery below 2.2 V without main power sets both low-battery bits.
// (R11) Battery-domain reset sets both low-battery status bits to one.
// (R12) Battery reset gives no wake; wake enable cleared by standby reset.
// (R13) Low battery gives no wake on standby; wakes when main returns.
// (R14) Management interrupt raised on main return when enable was set.
// (R15) Under main power status bits only update at main-power reset; the code also sets them at any battery-domain reset.
// (R16) Wake uses status/enable group six; interrupt uses group one.
// (R17) Wake output asserts when a wake status bit and its enable are set.
// (R18) Low-battery status bits stay set until software clears them.
`ifndef PCBM_PARAMS_SVH
`define PCBM_PARAMS_SVH
`define PCBM_CLK_PERIOD_NS   10
`define PCBM_PULSE_MS        500
`define PCBM_PULSE_CYC       ((`PCBM_PULSE_MS * 1000000) / `PCBM_CLK_PERIOD_NS)
`define PCBM_RSM_DELAY_MS    10
`define PCBM_RSM_DELAY_CYC   ((`PCBM_RSM_DELAY_MS * 1000000) / `PCBM_CLK_PERIOD_NS)
`define PCBM_POLICY_ON       2'h1
`define PCBM_POLICY_PREV     2'h2
`define PCBM_CNT_W           28
`endif

// >>> pcbm_pkg.sv
package pcbm_pkg;
  typedef enum logic [1:0] {
    PCBM_IDLE,
    PCBM_DECIDE,
    PCBM_PULSE,
    PCBM_DONE
  } pcbm_rec_t;
endpackage : pcbm_pkg

// >>> pcbm_lowbat_flags.sv
`timescale 1ns/1ps
// sticky low-battery status pair; set wins over software clear
module pcbm_lowbat_flags (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_set,
  input  wire logic i_clr_wake,
  input  wire logic i_clr_mgmt,
  output logic      o_wake_sts,
  output logic      o_mgmt_sts
);
  typedef struct packed {
    logic wake;
    logic mgmt;
  } pcbm_flag_t;

  pcbm_flag_t st_ff;
  pcbm_flag_t nxt_st;

  // status holds until cleared; a set in the clear cycle is kept
  always_comb begin
    nxt_st = st_ff;
    if (i_clr_wake) nxt_st.wake = 1'b0;
    if (i_clr_mgmt) nxt_st.mgmt = 1'b0;
    if (i_set) begin
      nxt_st.wake = 1'b1; // R18
      nxt_st.mgmt = 1'b1; // R18
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign o_wake_sts = st_ff.wake;
  assign o_mgmt_sts = st_ff.mgmt;
endmodule : pcbm_lowbat_flags

// >>> pcbm_top.sv
`timescale 1ns/1ps
`include "pcbm_params.svh"
// power button, supply gate, resume reset and low-battery latching
// the recovery pulse and the resume delay are counted in core clocks;
// both counters are 28 bits wide, enough for the half-second pulse at
// the nominal clock and at a clock up to five times faster; beyond that they need to be wider
// the battery inputs are levels from the supply monitors and are
// only captured while main power is away
module pcbm_top #(
  parameter logic [27:0] PULSE_CYC = 28'(`PCBM_PULSE_CYC),
  parameter logic [27:0] RSM_CYC   = 28'(`PCBM_RSM_DELAY_CYC)
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // front button and hub sleep level
  input  wire logic       i_front_button_in_n,
  input  wire logic       i_button_enable,
  input  wire logic       i_sleep_state_in_n,
  // outage recovery policy
  input  wire logic [1:0] i_after_failure_policy,
  input  wire logic       i_previous_state_on,
  // supply rails, resets and battery monitors
  input  wire logic       i_standby_above_trip,
  input  wire logic       i_main_power_reset,
  input  wire logic       i_battery_por,
  input  wire logic       i_batt_below_low,
  input  wire logic       i_batt_below_dead,
  input  wire logic       i_standby_por,
  input  wire logic       i_main_present,
  // event enables and software clears
  input  wire logic       i_wake_enable_group_six,
  input  wire logic       i_mgmt_int_enable_group_one,
  input  wire logic       i_wake_status_clear,
  input  wire logic       i_mgmt_status_clear,
  // pins toward the hub, the supply and the event logic
  output logic            o_button_request_out_n,
  output logic            o_supply_enable_out_n,
  output logic            o_resume_well_reset_n,
  output logic            o_wake_status_group_six,
  output logic            o_mgmt_int_status_group_one,
  output logic            o_wake_event_out_n,
  output logic            o_mgmt_int_out,
  output logic            o_battery_domain_reset
);
  typedef struct packed {
    // recovery sequence and its counters
    pcbm_pkg::pcbm_rec_t rec;
    logic [27:0]         pulse_cnt;
    logic [27:0]         rsm_cnt;
    // registered pins
    logic                btn_n;
    logic                supply_n;
    logic                rsm_n;
    logic                wake_n;
    logic                mgmt;
    // battery and event bookkeeping
    logic                wake_en;
    logic                dead_seen;
    logic                low_seen;
    logic                bat_rst;
    logic                set_flags;
  } pcbm_state_t;

  pcbm_state_t st_ff;
  pcbm_state_t nxt_st;
  logic        wake_sts;
  logic        mgmt_sts;

  // policy decode reused by the recovery branch
  function automatic logic want_on(input logic [1:0] pol, input logic prev);
    want_on = (pol == `PCBM_POLICY_ON) || ((pol == `PCBM_POLICY_PREV) && prev);
  endfunction : want_on

  // counter step shared by the resume delay and the recovery pulse
  function automatic logic [27:0] cnt_inc(input logic [27:0] val);
    cnt_inc = val + 28'h0000001;
  endfunction : cnt_inc

  pcbm_lowbat_flags u_flags (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_set      (st_ff.set_flags),
    .i_clr_wake (i_wake_status_clear),
    .i_clr_mgmt (i_mgmt_status_clear),
    .o_wake_sts (wake_sts),
    .o_mgmt_sts (mgmt_sts)
  );

  // all next-state logic; one copy of the state is filled here and the
  // flop process below registers it, so every output leaves from a flop
  always_comb begin
    nxt_st = st_ff;

    // one-cycle strobes drop back to zero unless raised further down
    nxt_st.set_flags = 1'b0;
    nxt_st.bat_rst   = 1'b0;

    // supply gate: a plain inversion of the hub's sleep level, one clock
    // late; the hub owns the on/off decision, this block only buffers it
    nxt_st.supply_n = ~i_sleep_state_in_n; // R5

    // resume reset and recovery both restart whenever standby drops, so
    // every standby rise gives exactly one recovery decision
    if (!i_standby_above_trip) begin
      nxt_st.rsm_cnt   = '0;
      nxt_st.rsm_n     = 1'b0;
      nxt_st.pulse_cnt = '0;
      nxt_st.rec       = pcbm_pkg::PCBM_IDLE;
    end else begin
      // keep the resume well in reset for the whole delay after the trip
      if (st_ff.rsm_cnt < RSM_CYC) begin
        nxt_st.rsm_cnt = cnt_inc(st_ff.rsm_cnt);
      end else begin
        nxt_st.rsm_n = 1'b1; // R8
      end

      // recovery waits for the released resume reset, so the hub is out
      // of reset before it sees the recovery pulse
      case (st_ff.rec)
        pcbm_pkg::PCBM_IDLE: begin
          if (st_ff.rsm_n) begin
            nxt_st.rec = pcbm_pkg::PCBM_DECIDE;
          end
        end
        pcbm_pkg::PCBM_DECIDE: begin
          nxt_st.pulse_cnt = '0;
          if (want_on(i_after_failure_policy, i_previous_state_on)) begin
            nxt_st.rec = pcbm_pkg::PCBM_PULSE; // R1
          end else begin
            nxt_st.rec = pcbm_pkg::PCBM_DONE; // R2
          end
        end
        pcbm_pkg::PCBM_PULSE: begin
          // fixed width keeps well clear of the hub's override time
          nxt_st.pulse_cnt = cnt_inc(st_ff.pulse_cnt); // R4
          if (st_ff.pulse_cnt >= PULSE_CYC - 28'h0000001) begin
            nxt_st.rec = pcbm_pkg::PCBM_DONE;
          end
        end
        // done holds until standby drops; the decision is never retried
        pcbm_pkg::PCBM_DONE: begin
          nxt_st.rec = pcbm_pkg::PCBM_DONE;
        end
        default: begin
          nxt_st.rec = pcbm_pkg::PCBM_IDLE;
        end
      endcase
    end

    // button output: the front button passes straight through while
    // enabled and the recovery pulse is merged in; a policy that keeps
    // the supply off never reaches the pulse state, so the pin is left alone
    nxt_st.btn_n = ~((i_button_enable && !i_front_button_in_n) // R3
                   || (nxt_st.rec == pcbm_pkg::PCBM_PULSE));

    // remember battery conditions seen while main power is away; under
    // main power nothing is captured, so a low-battery capture only sets status at main reset
    if (i_batt_below_dead && !i_main_present) begin
      nxt_st.dead_seen = 1'b1;
    end
    if (i_batt_below_low && !i_main_present) begin
      nxt_st.low_seen = 1'b1; // R15
    end

    // standby reset: the wake enable is not kept, and a dead battery seen
    // before it turns into a battery-domain reset pulse; a capture in the
    // very cycle of the standby reset waits for the next one
    if (i_standby_por) begin
      nxt_st.wake_en = 1'b0; // R12
      if (st_ff.dead_seen) begin
        nxt_st.bat_rst   = 1'b1; // R9
        nxt_st.dead_seen = 1'b0;
      end
    end else if (i_main_present) begin
      nxt_st.wake_en = i_wake_enable_group_six;
    end

    // a battery-domain reset sets both status bits
    if (i_battery_por || st_ff.bat_rst) begin
      nxt_st.set_flags = 1'b1; // R11
    end
    // main reset consumes a low-battery capture; clearing the capture keeps
    // a later main reset from setting the bits a second time
    if (i_main_power_reset && st_ff.low_seen) begin
      nxt_st.set_flags = 1'b1; // R10
      nxt_st.low_seen  = 1'b0;
    end

    // events only reach the outputs once main power is up; under standby
    // alone the status just waits, so no wake comes from standby
    nxt_st.wake_n = ~(i_main_present && st_ff.wake_en && wake_sts); // R13 R16 R17
    nxt_st.mgmt   = i_main_present && i_mgmt_int_enable_group_one && mgmt_sts; // R14 R16
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    // reset leaves the pins idle: no request, supply off, no wake
    if (!i_rst_n) begin
      st_ff          <= '0;
      st_ff.rec      <= pcbm_pkg::PCBM_IDLE;
      st_ff.btn_n    <= 1'b1;
      st_ff.supply_n <= 1'b1;
      st_ff.wake_n   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // every pin leaves straight from a flop
  assign o_button_request_out_n      = st_ff.btn_n;
  assign o_supply_enable_out_n       = st_ff.supply_n;
  assign o_resume_well_reset_n       = st_ff.rsm_n;
  assign o_wake_status_group_six     = wake_sts;
  assign o_mgmt_int_status_group_one = mgmt_sts;
  assign o_wake_event_out_n          = st_ff.wake_n;
  assign o_mgmt_int_out              = st_ff.mgmt;
  assign o_battery_domain_reset      = st_ff.bat_rst;
endmodule : pcbm_top

// >>> pcbm_chk.sv
`timescale 1ns/1ps
// port watch; the counts come in from the design through the bind
module pcbm_chk #(
  parameter logic [27:0] PULSE_CYC = 28'h14,
  parameter logic [27:0] RSM_CYC   = 28'hA
) (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_sleep_state_in_n,
  input wire logic       i_front_button_in_n,
  input wire logic       i_button_enable,
  input wire logic       i_standby_above_trip,
  input wire logic       i_main_present,
  input wire logic [1:0] i_after_failure_policy,
  input wire logic       i_wake_enable_group_six,
  input wire logic       i_mgmt_int_enable_group_one,
  input wire logic       i_wake_status_clear,
  input wire logic       i_main_power_reset,
  input wire logic       i_battery_por,
  input wire logic       i_standby_por,
  input wire logic       o_button_request_out_n,
  input wire logic       o_supply_enable_out_n,
  input wire logic       o_resume_well_reset_n,
  input wire logic       o_wake_status_group_six,
  input wire logic       o_mgmt_int_status_group_one,
  input wire logic       o_wake_event_out_n,
  input wire logic       o_mgmt_int_out
);
  // sampled edges from standby rise to resume release, and pulse width;
  // only short counts keep these delays within reach of the tools
  localparam int RSM_LAT   = int'(RSM_CYC) + 1;
  localparam int PULSE_LAT = int'(PULSE_CYC);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // output lags its cause by one edge, so the first edge after reset is skipped
  a_supply_inverse: assert property ($past(i_rst_n) |-> o_supply_enable_out_n == !$past(i_sleep_state_in_n))
    else $error("supply not inverse of sleep");
  a_button_hold: assert property (i_button_enable && !i_front_button_in_n |=> !o_button_request_out_n)
    else $error("button output not held low");
  a_resume_bound: assert property ($rose(i_standby_above_trip) |-> !o_resume_well_reset_n ##RSM_LAT o_resume_well_reset_n)
    else $error("resume reset not released");
  a_pulse_on: assert property ($rose(o_resume_well_reset_n) && i_after_failure_policy == 2'h1 |-> ##[1:4] !o_button_request_out_n)
    else $error("no recovery pulse");
  a_pulse_width: assert property ($rose(o_resume_well_reset_n) && i_after_failure_policy == 2'h1 && !i_button_enable |-> ##2 !o_button_request_out_n ##PULSE_LAT o_button_request_out_n)
    else $error("recovery pulse width wrong");
  a_pulse_off: assert property ($rose(o_resume_well_reset_n) && i_after_failure_policy == 2'h0 && i_front_button_in_n |-> o_button_request_out_n [*8])
    else $error("pulse with policy off");
  a_wake_gate: assert property (o_wake_status_group_six && i_wake_enable_group_six && i_main_present |-> ##[0:3] !o_wake_event_out_n)
    else $error("wake output missing");
  a_mgmt_gate: assert property (o_mgmt_int_status_group_one && i_mgmt_int_enable_group_one && i_main_present |-> ##[0:3] o_mgmt_int_out)
    else $error("mgmt interrupt missing");
  a_set_cause: assert property ($rose(o_mgmt_int_status_group_one) |-> $past(i_main_power_reset, 2) || $past(i_battery_por, 2) || $past(i_standby_por, 3))
    else $error("status set without reset");
  a_wake_sticky: assert property (o_wake_status_group_six && !i_wake_status_clear |=> o_wake_status_group_six)
    else $error("wake status dropped");
endmodule : pcbm_chk
bind pcbm_top pcbm_chk #(.PULSE_CYC(PULSE_CYC), .RSM_CYC(RSM_CYC)) u_chk (.*);

// >>> pcbm_hub.sv
`timescale 1ns/1ps
// hub stand-in: each button request toggles the sleep level after a lag
module pcbm_hub #(
  parameter int LAG = 3
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_button_n,
  output logic      o_sleep_n
);
  localparam logic OUTAGE_BIT = 1'h1;
  int   lag_ff;
  logic btn_ff;
  // act on the falling request edge only, so a held button toggles once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lag_ff    <= 0;
      btn_ff    <= 1'h1;
      o_sleep_n <= 1'h0;
    end else begin
      btn_ff <= i_button_n;
      if (btn_ff && !i_button_n && OUTAGE_BIT) lag_ff <= LAG;
      else if (lag_ff > 0) lag_ff <= lag_ff - 1;
      if (lag_ff == 1) o_sleep_n <= !o_sleep_n;
    end
  end
endmodule : pcbm_hub

// >>> pcbm_top_tb.sv
`timescale 1ns/1ps
module pcbm_top_tb;
  localparam logic [27:0] PC = 28'h14;
  localparam logic [27:0] RC = 28'hA;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_front_button_in_n = 1'h1, i_button_enable = 1'h0;
  logic i_previous_state_on = 1'h0, i_standby_above_trip = 1'h0, i_main_power_reset = 1'h0;
  logic i_battery_por = 1'h0, i_batt_below_low = 1'h0, i_batt_below_dead = 1'h0;
  logic i_standby_por = 1'h0, i_main_present = 1'h0, i_wake_enable_group_six = 1'h0;
  logic i_mgmt_int_enable_group_one = 1'h0, i_wake_status_clear = 1'h0, i_mgmt_status_clear = 1'h0;
  logic [1:0] i_after_failure_policy = 2'h0;
  logic i_sleep_state_in_n, o_button_request_out_n, o_supply_enable_out_n, o_resume_well_reset_n;
  logic o_wake_status_group_six, o_mgmt_int_status_group_one, o_wake_event_out_n;
  logic o_mgmt_int_out, o_battery_domain_reset;
  int   failures = 0, n_tests = 0, k, lo;
  // free-running clock; inputs always move 1 ns after a rising edge
  always #5 i_clk = !i_clk;
  pcbm_top #(.PULSE_CYC(PC), .RSM_CYC(RC)) dut (.*);
  pcbm_hub u_hub (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_button_n(o_button_request_out_n),
                  .o_sleep_n(i_sleep_state_in_n));
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  task automatic chk(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk
  task automatic chk_n(input int got, input int exp, input string what);
    n_tests++;
    if (got != exp) begin
      failures++;
      $display("[FAIL] %0t %s got %0d", $time, what, got);
    end
  endtask : chk_n
  task automatic close_out;
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // one outage return: reset, standby rise, bounded wait, then count the pulse
  task automatic recover(input logic [1:0] pol, input logic prev, input int exp_lo);
    i_after_failure_policy = pol;
    i_previous_state_on = prev;
    i_standby_above_trip = 1'h0;
    i_rst_n = 1'h0;
    step(5);
    i_rst_n = 1'h1;
    chk(o_resume_well_reset_n, 1'h0, "resume in reset");
    i_standby_above_trip = 1'h1;
    k = 0;
    while (o_resume_well_reset_n !== 1'h1) begin
      k++;
      if (k > 40) begin
        failures++;
        close_out();
      end
      step(1);
    end
    chk(k >= RC, 1'h1, "resume early");
    lo = 0;
    repeat (40) begin
      step(1);
      lo += !o_button_request_out_n;
    end
    chk_n(lo, exp_lo, "pulse length");
    chk(o_supply_enable_out_n, exp_lo == 0, "supply after recovery");
  endtask : recover
  initial begin
    recover(2'h1, 1'h0, PC);
    recover(2'h2, 1'h1, PC);
    recover(2'h2, 1'h0, 0);
    recover(2'h0, 1'h1, 0);
    recover(2'h3, 1'h1, 0);
    i_button_enable = 1'h1;
    i_front_button_in_n = 1'h0;
    repeat (6) begin
      step(1);
      chk(o_button_request_out_n, 1'h0, "button hold");
    end
    i_front_button_in_n = 1'h1;
    step(2);
    chk(o_button_request_out_n, 1'h1, "button release");
    i_batt_below_low = 1'h1;
    i_wake_enable_group_six = 1'h1;
    i_mgmt_int_enable_group_one = 1'h1;
    step(4);
    chk(o_wake_event_out_n, 1'h1, "wake on standby");
    i_main_present = 1'h1;
    i_main_power_reset = 1'h1;
    step(1);
    i_main_power_reset = 1'h0;
    step(4);
    chk(o_wake_status_group_six, 1'h1, "wake status");
    chk(o_mgmt_int_status_group_one, 1'h1, "mgmt status");
    chk(o_wake_event_out_n, 1'h0, "wake out");
    chk(o_mgmt_int_out, 1'h1, "mgmt out");
    i_wake_status_clear = 1'h1;
    step(1);
    i_wake_status_clear = 1'h0;
    step(4);
    chk(o_wake_status_group_six, 1'h0, "wake clear");
    chk(o_mgmt_int_status_group_one, 1'h1, "mgmt kept");
    // the dead battery is captured one edge before the standby reset uses it
    i_mgmt_status_clear = 1'h1;
    i_main_present = 1'h0;
    i_batt_below_dead = 1'h1;
    step(1);
    i_mgmt_status_clear = 1'h0;
    chk(o_mgmt_int_status_group_one, 1'h0, "mgmt clear");
    i_standby_por = 1'h1;
    step(1);
    i_standby_por = 1'h0;
    lo = 0;
    repeat (5) begin
      lo += o_battery_domain_reset;
      step(1);
    end
    chk_n(lo, 1, "battery reset");
    chk(o_mgmt_int_status_group_one, 1'h1, "por status");
    chk(o_wake_status_group_six, 1'h1, "por wake status");
    chk(o_wake_event_out_n, 1'h1, "por no wake");
    // a battery-domain reset from its own input sets the status again
    i_mgmt_status_clear = 1'h1;
    step(1);
    i_mgmt_status_clear = 1'h0;
    chk(o_mgmt_int_status_group_one, 1'h0, "mgmt clear again");
    i_battery_por = 1'h1;
    step(1);
    i_battery_por = 1'h0;
    step(2);
    chk(o_mgmt_int_status_group_one, 1'h1, "battery por status");
    close_out();
  end
endmodule : pcbm_top_tb
